// ===== logic/vstil_lookup.sv
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module vstil_lookup
   import vstil_pkg::*;
(
   input  wire logic        REF_CLK,
   input  wire logic        RESET_N,
   input  wire logic [5:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   input  wire vstil_req_s  LKP_REQ,
   output vstil_res_s       LKP_RES
);

   logic                 wait_q;
   logic [31:0]          rdata_q;
   logic [31:0]          rdata_d;
   logic                 bus_wr;
   logic [31:0]          wmask;
   logic [31:0]          wval;
   logic                 lookup_en_q;
   logic [NUM_PORTS-1:0] port_fwd_q;
   logic [NUM_PORTS-1:0] port_lrn_q;
   logic [NUM_PORTS-1:0] igr_filt_q;
   logic [NUM_PORTS-1:0] isolated_q;
   logic [NUM_PORTS-1:0] community_q;
   logic [IDX_W-1:0]     tbl_idx_q;
   vstil_vlan_lo_s       vlan_lo_q;
   vstil_vlan_hi_s       vlan_hi_q;
   vstil_mstp_s          mstp_q;
   logic [STICKY_W-1:0]  sticky_q;
   logic [STICKY_W-1:0]  sticky_set;
   logic [3:0]           cmd;
   vstil_vlan_s          vlan_tbl [VLAN_DEPTH];
   vstil_mstp_s          mstp_tbl [MSTP_DEPTH];
   vstil_vlan_s          ent_d;
   vstil_mstp_s          stp_d;
   logic [IDX_W-1:0]     vidx;
   logic                 s1_valid_q;
   vstil_req_s           s1_req_q;
   vstil_vlan_s          s1_ent_q;
   vstil_mstp_s          s1_stp_q;
   logic                 s1_en_q;
   vstil_res_s           res_d;
   vstil_res_s           res_q;
   logic                 front;
   logic [1:0]           ptype;
   logic [NUM_PORTS-1:0] mbr;

   // Selects the bit of a port mask that belongs to a port; internal ports give 0
   function automatic logic pbit(input logic [NUM_PORTS-1:0] m, input logic [PORT_W-1:0] p);
      pbit = |(m & (11'h001 << p));
   endfunction

   assign AVS_READDATA    = rdata_q;
   assign AVS_WAITREQUEST = wait_q;
   assign LKP_RES         = res_q;

   // Waitrequest drops for one cycle after a request is seen: fixed two-edge answer
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~((AVS_READ | AVS_WRITE) & wait_q);
      end
   end

   // The write takes effect only at the edge where the master sees waitrequest low
   assign bus_wr = AVS_WRITE & ~wait_q;
   assign wmask  = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                    {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
   assign cmd    = (bus_wr && AVS_ADDRESS == OFS_TBL_CMD) ? (AVS_WRITEDATA[3:0] & wmask[3:0]) : 4'h0;

   // Read mux; unmapped offsets read as zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      unique case (AVS_ADDRESS)
         OFS_CTRL:      rdata_d[0] = lookup_en_q;
         OFS_PORT_FWD:  rdata_d[NUM_PORTS-1:0] = port_fwd_q;
         OFS_PORT_LRN:  rdata_d[NUM_PORTS-1:0] = port_lrn_q;
         OFS_IGR_FILT:  rdata_d[NUM_PORTS-1:0] = igr_filt_q;
         OFS_ISOLATED:  rdata_d[NUM_PORTS-1:0] = isolated_q;
         OFS_COMMUNITY: rdata_d[NUM_PORTS-1:0] = community_q;
         OFS_TBL_INDEX: rdata_d[IDX_W-1:0] = tbl_idx_q;
         OFS_VLAN_LO:   rdata_d = vlan_lo_q;
         OFS_VLAN_HI:   rdata_d = vlan_hi_q;
         OFS_MSTP:      rdata_d = mstp_q;
         OFS_STICKY:    rdata_d[STICKY_W-1:0] = sticky_q;
         default:       rdata_d = 32'h0000_0000;
      endcase
   end

   // Read data is captured one edge early so it stands at the acknowledging edge
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rdata_q <= 32'h0000_0000;
      end else if (AVS_READ && wait_q) begin
         rdata_q <= rdata_d;
      end
   end

   // Global configuration registers with byte-lane merge
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         lookup_en_q <= RST_LOOKUP_EN;
         port_fwd_q  <= RST_PORT_MASK;
         port_lrn_q  <= RST_PORT_MASK;
         igr_filt_q  <= RST_PORT_MASK;
         isolated_q  <= RST_PORT_MASK;
         community_q <= RST_PORT_MASK;
         tbl_idx_q   <= '0;
      end else if (bus_wr) begin
         unique case (AVS_ADDRESS)
            OFS_CTRL:      lookup_en_q <= wmask[0] ? AVS_WRITEDATA[0] : lookup_en_q;
            OFS_PORT_FWD:  port_fwd_q  <= wval[NUM_PORTS-1:0];
            OFS_PORT_LRN:  port_lrn_q  <= wval[NUM_PORTS-1:0];
            OFS_IGR_FILT:  igr_filt_q  <= wval[NUM_PORTS-1:0];
            OFS_ISOLATED:  isolated_q  <= wval[NUM_PORTS-1:0];
            OFS_COMMUNITY: community_q <= wval[NUM_PORTS-1:0];
            OFS_TBL_INDEX: tbl_idx_q   <= wval[IDX_W-1:0];
            default:       lookup_en_q <= lookup_en_q;
         endcase
      end
   end

   // Merged write value against the currently addressed register
   assign wval = (rdata_d & ~wmask) | (AVS_WRITEDATA & wmask);

   // Table staging words: loaded by software or by a table read command
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         vlan_lo_q <= '0;
         vlan_hi_q <= '0;
         mstp_q    <= '0;
      end else begin
         if (cmd[CMD_VLAN_RD] && tbl_idx_q < VLAN_DEPTH) begin
            vlan_lo_q <= vlan_tbl[tbl_idx_q].lo;
            vlan_hi_q <= vlan_tbl[tbl_idx_q].hi;
         end else if (bus_wr && AVS_ADDRESS == OFS_VLAN_LO) begin
            vlan_lo_q <= wval;
         end else if (bus_wr && AVS_ADDRESS == OFS_VLAN_HI) begin
            vlan_hi_q <= wval;
         end
         if (cmd[CMD_MSTP_RD] && tbl_idx_q < MSTP_DEPTH) begin
            mstp_q <= mstp_tbl[tbl_idx_q[PTR_W-1:0]];
         end else if (bus_wr && AVS_ADDRESS == OFS_MSTP) begin
            mstp_q <= wval;
         end
      end
   end

   // Table storage; contents are undefined until software writes them
   always_ff @(posedge REF_CLK) begin
      if (cmd[CMD_VLAN_WR] && tbl_idx_q < VLAN_DEPTH) begin
         vlan_tbl[tbl_idx_q] <= {vlan_hi_q, vlan_lo_q};
      end
      if (cmd[CMD_MSTP_WR] && tbl_idx_q < MSTP_DEPTH) begin
         mstp_tbl[tbl_idx_q[PTR_W-1:0]] <= mstp_q;
      end
   end

   // Stage 1 lookup: VLAN entry, then the spanning-tree entry it points to
   always_comb begin
      vidx  = {LKP_REQ.vsi_ena, LKP_REQ.vid};
      ent_d = '0;
      stp_d = '0;
      if (lookup_en_q) begin
         if (vidx < VLAN_DEPTH) begin
            ent_d = vlan_tbl[vidx];
         end
         if (ent_d.hi.mstp_ptr < MSTP_DEPTH) begin
            stp_d = mstp_tbl[ent_d.hi.mstp_ptr];
         end
      end else begin
         ent_d.lo.port_mask = '1;
         stp_d.fwd_mask     = '1;
         stp_d.lrn_mask     = '1;
      end
   end

   // Stage 1 registers; a new request is taken every cycle
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s1_valid_q <= 1'b0;
         s1_req_q   <= '0;
         s1_ent_q   <= '0;
         s1_stp_q   <= '0;
         s1_en_q    <= 1'b0;
      end else begin
         s1_valid_q <= LKP_REQ.valid;
         s1_req_q   <= LKP_REQ;
         s1_ent_q   <= ent_d;
         s1_stp_q   <= stp_d;
         s1_en_q    <= lookup_en_q;
      end
   end

   // Stage 2: filtering, learning and private VLAN decisions
   always_comb begin
      front      = s1_req_q.port < FIRST_INTERNAL_PORT;
      mbr        = s1_ent_q.lo.port_mask;
      sticky_set = '0;
      ptype      = 2'h0;
      res_d      = '0;
      res_d.l2_fwd = 1'b1;
      res_d.l2_lrn = 1'b1;
      if (s1_req_q.cpu_inject) begin
         res_d.bypass = 1'b1; // Injected frames leave untouched
         mbr          = '1;
      end else if (!front) begin
         res_d.l2_lrn = 1'b0;
      end else begin
         if (!pbit(port_fwd_q, s1_req_q.port)) begin
            res_d.l2_fwd = 1'b0;
            sticky_set[ST_PORT_FWD_DENY] = 1'b1;
         end
         if (!pbit(port_lrn_q, s1_req_q.port)) begin
            res_d.l2_lrn = 1'b0;
            sticky_set[ST_PORT_LRN_DENY] = 1'b1;
         end
         if (s1_en_q) begin
            sticky_set[ST_VLAN_EMPTY] = (mbr == '0);
            if ((pbit(igr_filt_q, s1_req_q.port) || s1_ent_q.lo.igr_filter_ena) &&
                !pbit(mbr, s1_req_q.port)) begin
               res_d.l2_fwd = 1'b0;
               res_d.l2_lrn = 1'b0;
               sticky_set[ST_IGR_FILTER] = 1'b1;
            end else begin
               if (!pbit(s1_stp_q.fwd_mask, s1_req_q.port)) begin
                  res_d.l2_fwd = 1'b0;
                  sticky_set[ST_MSTP_DISCARD] = 1'b1;
               end
               if (s1_ent_q.lo.lrn_dis) begin
                  res_d.l2_lrn = 1'b0;
                  sticky_set[ST_VLAN_LRN_DENY] = 1'b1;
               end else if (!pbit(s1_stp_q.lrn_mask, s1_req_q.port)) begin
                  res_d.l2_lrn = 1'b0;
                  sticky_set[ST_MSTP_LRN_DENY] = 1'b1;
               end
               if (s1_ent_q.hi.private_ena) begin
                  if (pbit(community_q, s1_req_q.port)) begin
                     ptype = 2'h1;
                  end
                  if (pbit(isolated_q, s1_req_q.port)) begin
                     ptype = 2'h2;
                  end
                  if (ptype == 2'h2) begin
                     mbr = mbr & ~isolated_q & ~community_q;
                  end else if (ptype == 2'h1) begin
                     mbr = mbr & ~isolated_q;
                  end
                  // Promiscuous ingress keeps the full member mask
               end
            end
         end
      end
      res_d.valid       = s1_valid_q;
      res_d.vlan_mask   = mbr & port_fwd_q & s1_stp_q.fwd_mask;
      res_d.ifid        = s1_ent_q.hi.fid;
      res_d.mirror      = s1_ent_q.lo.mirror_ena;
      res_d.flood_dis   = s1_ent_q.lo.flood_dis;
      res_d.sec_fwd_ena = s1_ent_q.lo.sec_fwd_ena;
      res_d.rleg_ena    = s1_ent_q.hi.rleg_ena;
      res_d.irleg       = s1_ent_q.hi.vmid;
      res_d.evid        = s1_req_q.vid;
      res_d.efid        = s1_req_q.dmac_mc ? {s1_req_q.vsi_ena, s1_req_q.vid} : s1_ent_q.hi.fid;
      if (s1_req_q.cpu_inject) begin
         res_d.vlan_mask = '1;
      end
   end

   // Result register: every output of the lookup comes from here
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         res_q <= '0;
      end else begin
         res_q <= res_d;
      end
   end

   // Diagnostic events: write one to clear, a same-cycle event wins
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sticky_q <= '0;
      end else begin
         sticky_q <= (sticky_q & ~((bus_wr && AVS_ADDRESS == OFS_STICKY) ?
                                   (AVS_WRITEDATA[STICKY_W-1:0] & wmask[STICKY_W-1:0]) : '0))
                     | (s1_valid_q ? sticky_set : '0);
      end
   end

   AST_LATENCY: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      LKP_REQ.valid |-> ##2 LKP_RES.valid)
      else $error("lookup result did not appear two cycles after the request");

   AST_DEST_MASK: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      LKP_RES.valid && !LKP_RES.bypass |->
         (LKP_RES.vlan_mask & ~($past(port_fwd_q) & $past(s1_stp_q.fwd_mask))) == '0)
      else $error("destination mask holds a port blocked by forward state");

   AST_FID_OUT: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      LKP_REQ.valid && lookup_en_q && !LKP_REQ.vsi_ena |->
         ##2 LKP_RES.ifid == $past(vlan_tbl[LKP_REQ.vid].hi.fid, 2))
      else $error("filter identifier not taken from the VLAN entry");

   AST_EFID_SEL: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      s1_valid_q ##1 LKP_RES.valid |->
         LKP_RES.efid == ($past(s1_req_q.dmac_mc) ? {$past(s1_req_q.vsi_ena), LKP_RES.evid} : LKP_RES.ifid))
      else $error("lookup identifier chosen wrongly for unicast or multicast");

   AST_LRN_DIS: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      s1_valid_q && s1_en_q && !s1_req_q.cpu_inject && s1_ent_q.lo.lrn_dis |=> !LKP_RES.l2_lrn)
      else $error("learning allowed on a VLAN with learning disabled");

   AST_INTERNAL_NOLRN: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      s1_valid_q && !s1_req_q.cpu_inject && s1_req_q.port >= FIRST_INTERNAL_PORT
         |=> !LKP_RES.l2_lrn && LKP_RES.l2_fwd)
      else $error("internal port frame learned or filtered");

   AST_STP_BLOCK: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      s1_valid_q && !s1_req_q.cpu_inject && s1_req_q.port < FIRST_INTERNAL_PORT &&
         !pbit(s1_stp_q.fwd_mask, s1_req_q.port) |=> !LKP_RES.l2_fwd)
      else $error("frame forwarded from a spanning-tree blocked port");

   AST_PORT_LRN: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      s1_valid_q && !s1_req_q.cpu_inject && s1_req_q.port < FIRST_INTERNAL_PORT &&
         !pbit(port_lrn_q, s1_req_q.port) |=> !LKP_RES.l2_lrn)
      else $error("learning allowed on a port with learning state off");

   AST_ISOLATED: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      s1_valid_q && s1_en_q && !s1_req_q.cpu_inject && s1_ent_q.hi.private_ena &&
         s1_req_q.port < FIRST_INTERNAL_PORT && pbit(isolated_q, s1_req_q.port) &&
         pbit(s1_ent_q.lo.port_mask, s1_req_q.port)
         |=> (LKP_RES.vlan_mask & ($past(isolated_q) | $past(community_q))) == '0)
      else $error("isolated port reaches a non-promiscuous port");

   AST_BUS_ANSWER: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
      else $error("bus answer not given on the following edge");
endmodule

// ===== logic/vstil_pkg.sv
package vstil_pkg;

   // Table and field dimensions
   localparam int NUM_PORTS  = 11;
   localparam int VLAN_DEPTH = 4224;
   localparam int MSTP_DEPTH = 66;
   localparam int IDX_W      = 13;
   localparam int VID_W      = 12;
   localparam int PORT_W     = 4;
   localparam int PTR_W      = 7;
   localparam int FID_W      = 13;
   localparam int VMID_W     = 5;
   localparam int CTRL_W     = 16;
   localparam int STICKY_W   = 7;

   // Port numbers from here up are the CPU port and the virtual device ports
   localparam logic [PORT_W-1:0] FIRST_INTERNAL_PORT = 4'hB;

   // Register byte offsets on the Avalon slave
   localparam logic [5:0] OFS_CTRL      = 6'h00;
   localparam logic [5:0] OFS_PORT_FWD  = 6'h04;
   localparam logic [5:0] OFS_PORT_LRN  = 6'h08;
   localparam logic [5:0] OFS_IGR_FILT  = 6'h0C;
   localparam logic [5:0] OFS_ISOLATED  = 6'h10;
   localparam logic [5:0] OFS_COMMUNITY = 6'h14;
   localparam logic [5:0] OFS_TBL_INDEX = 6'h18;
   localparam logic [5:0] OFS_VLAN_LO   = 6'h1C;
   localparam logic [5:0] OFS_VLAN_HI   = 6'h20;
   localparam logic [5:0] OFS_MSTP      = 6'h24;
   localparam logic [5:0] OFS_TBL_CMD   = 6'h28;
   localparam logic [5:0] OFS_STICKY    = 6'h2C;

   // Reset values
   localparam logic                 RST_LOOKUP_EN = 1'b0;
   localparam logic [NUM_PORTS-1:0] RST_PORT_MASK = 11'h000;

   // Table command bit positions
   localparam int CMD_VLAN_WR = 0;
   localparam int CMD_VLAN_RD = 1;
   localparam int CMD_MSTP_WR = 2;
   localparam int CMD_MSTP_RD = 3;

   // Sticky event bit positions
   localparam int ST_PORT_FWD_DENY = 0;
   localparam int ST_PORT_LRN_DENY = 1;
   localparam int ST_VLAN_EMPTY    = 2;
   localparam int ST_IGR_FILTER    = 3;
   localparam int ST_MSTP_DISCARD  = 4;
   localparam int ST_VLAN_LRN_DENY = 5;
   localparam int ST_MSTP_LRN_DENY = 6;

   // VLAN entry low word, laid out as seen at OFS_VLAN_LO
   typedef struct packed {
      logic                 mirror_ena;
      logic                 lrn_dis;
      logic                 flood_dis;
      logic                 sec_fwd_ena;
      logic                 igr_filter_ena;
      logic [CTRL_W-1:0]    ctrl_val;
      logic [NUM_PORTS-1:0] port_mask;
   } vstil_vlan_lo_s;

   // VLAN entry high word, laid out as seen at OFS_VLAN_HI
   typedef struct packed {
      logic [4:0]        pad;
      logic              private_ena;
      logic              rleg_ena;
      logic [VMID_W-1:0] vmid;
      logic [PTR_W-1:0]  mstp_ptr;
      logic [FID_W-1:0]  fid;
   } vstil_vlan_hi_s;

   typedef struct packed {
      vstil_vlan_hi_s hi;
      vstil_vlan_lo_s lo;
   } vstil_vlan_s;

   // Spanning-tree entry, laid out as seen at OFS_MSTP
   typedef struct packed {
      logic [4:0]           pad_hi;
      logic [NUM_PORTS-1:0] lrn_mask;
      logic [4:0]           pad_lo;
      logic [NUM_PORTS-1:0] fwd_mask;
   } vstil_mstp_s;

   // Lookup request from the classifier
   typedef struct packed {
      logic              valid;
      logic              cpu_inject;
      logic              vsi_ena;
      logic [VID_W-1:0]  vid;
      logic [PORT_W-1:0] port;
      logic              dmac_mc;
   } vstil_req_s;

   // Lookup result for the forwarding stages
   typedef struct packed {
      logic                 valid;
      logic                 bypass;
      logic                 l2_fwd;
      logic                 l2_lrn;
      logic                 mirror;
      logic                 flood_dis;
      logic                 sec_fwd_ena;
      logic                 rleg_ena;
      logic [VMID_W-1:0]    irleg;
      logic [FID_W-1:0]     ifid;
      logic [FID_W-1:0]     efid;
      logic [VID_W-1:0]     evid;
      logic [NUM_PORTS-1:0] vlan_mask;
   } vstil_res_s;

endpackage

// ===== verif/vlan_spanning_tree_ingress_lookup_tb.sv
`timescale 1ns/1ps
module vlan_spanning_tree_ingress_lookup_tb;
   import vstil_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [5:0]  adr = 6'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] rq;
   logic        wrq;
   vstil_req_s  req = '0;
   vstil_res_s  res;
   vstil_res_s  got;
   int          cnt;
   int          fail_count = 0;
   int          total_checks = 0;
   logic [3:0]  pp [3] = '{4'h0, 4'h2, 4'h5};
   logic [10:0] pm [3] = '{11'h7F0, 11'h7FC, 11'h7FF};
   logic [2:0]  req_hdr = 3'h4;
   logic [3:0]  be = 4'hF;

   vstil_lookup i_vstil_lookup (.REF_CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wrq),
      .LKP_REQ(req), .LKP_RES(res));
   vstil_stage_model i_vstil_stage_model (.REF_CLK(clk), .RESET_N(rst_n), .LKP_RES(res), .last_res(got),
      .res_count(cnt));

   // Clock of 10 ns
   always #5 clk = ~clk;

   // Avalon cycle: hold everything until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      rd <= !w;
      wr <= w;
      adr <= a;
      wdat <= d;
      // No limit of its own: only the watchdog may end a wait
      do begin
         @(posedge clk);
      end while (wrq !== 1'b0);
      rq = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // One or two back-to-back requests on VID 5; waits for every result pulse
   task automatic lk(input logic [3:0] p, input logic mc, input logic [3:0] p2);
      int n;
      n = cnt + ((p2 != 4'hF) ? 2 : 1);
      req <= {req_hdr, 12'h005, p, mc};
      @(posedge clk);
      if (p2 != 4'hF) begin
         req <= {req_hdr, 12'h005, p2, mc};
         @(posedge clk);
      end
      req <= '0;
      for (int i = 0; i < 20 && cnt < n; i++) @(posedge clk);
      chk(cnt, n);
   endtask

   task automatic ex(input logic f, input logic l, input logic [10:0] m);
      chk({got.l2_fwd, got.l2_lrn, got.vlan_mask}, {f, l, m});
   endtask

   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Hang guard, far beyond the roughly 150 cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      tally_and_finish();
   end

   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, OFS_CTRL, 32'h0);
      chk(rq, 32'h0);
      bus(1'b0, 6'h30, 32'h0);
      chk(rq, 32'h0);
      lk(4'h2, 1'b0, 4'hF);
      ex(1'b0, 1'b0, 11'h000);
      bus(1'b1, OFS_PORT_FWD, 32'h7FF);
      // Upper lane only: bits 10:8 cleared, the low lane keeps its value
      be <= 4'h2;
      bus(1'b1, OFS_PORT_FWD, 32'h0);
      be <= 4'hF;
      bus(1'b0, OFS_PORT_FWD, 32'h0);
      chk(rq, 32'h0FF);
      bus(1'b1, OFS_PORT_FWD, 32'h7FF);
      bus(1'b1, OFS_PORT_LRN, 32'h7FF);
      lk(4'h2, 1'b0, 4'hF);
      ex(1'b1, 1'b1, 11'h7FF);
      $display("test defaults done");
      // VLAN 5 points at tree 3, where port 1 is blocked and port 2 may not learn
      bus(1'b1, OFS_CTRL, 32'h1);
      bus(1'b1, OFS_TBL_INDEX, 32'h3);
      bus(1'b1, OFS_MSTP, 32'h07FB07FD);
      bus(1'b1, OFS_TBL_CMD, 32'h4);
      bus(1'b1, OFS_TBL_INDEX, 32'h5);
      bus(1'b1, OFS_VLAN_LO, {5'h17, 16'hABCD, 11'h00F});
      bus(1'b1, OFS_VLAN_HI, {7'h01, 5'h15, 7'h03, 13'h0123});
      bus(1'b1, OFS_TBL_CMD, 32'h1);
      bus(1'b1, OFS_VLAN_LO, 32'h0);
      bus(1'b1, OFS_TBL_CMD, 32'h2);
      bus(1'b0, OFS_VLAN_LO, 32'h0);
      chk(rq, {5'h17, 16'hABCD, 11'h00F});
      lk(4'h2, 1'b0, 4'hF);
      ex(1'b1, 1'b0, 11'h00D);
      // Split so that no field falls off the 32-bit compare
      chk({got.mirror, got.flood_dis, got.sec_fwd_ena, got.rleg_ena}, 4'hF);
      chk({got.irleg, got.ifid}, {5'h15, 13'h0123});
      chk({got.efid, got.evid}, {13'h0123, 12'h005});
      lk(4'h2, 1'b1, 4'hF);
      chk(got.efid, 13'h0005);
      lk(4'h1, 1'b0, 4'hF);
      ex(1'b0, 1'b1, 11'h00D);
      lk(4'h1, 1'b0, 4'h5);
      ex(1'b0, 1'b0, 11'h00D);
      lk(4'hB, 1'b0, 4'hF);
      ex(1'b1, 1'b0, 11'h00D);
      $display("test vlan and tree done");
      // Private VLAN: ports 0,1 isolated, ports 2,3 community, rest promiscuous
      bus(1'b1, OFS_TBL_INDEX, 32'h3);
      bus(1'b1, OFS_MSTP, 32'h07FF07FF);
      bus(1'b1, OFS_TBL_CMD, 32'h4);
      bus(1'b1, OFS_TBL_INDEX, 32'h5);
      // Learning is switched off for the whole VLAN here
      bus(1'b1, OFS_VLAN_LO, 32'h400007FF);
      bus(1'b1, OFS_VLAN_HI, {7'h03, 5'h15, 7'h03, 13'h0123});
      bus(1'b1, OFS_TBL_CMD, 32'h1);
      bus(1'b1, OFS_ISOLATED, 32'h003);
      bus(1'b1, OFS_COMMUNITY, 32'h00C);
      for (int i = 0; i < 3; i++) begin
         lk(pp[i], 1'b0, 4'hF);
         ex(1'b1, 1'b0, pm[i]);
      end
      // Injected frame skips every filter and reaches all ports
      req_hdr = 3'h6;
      lk(4'h2, 1'b0, 4'hF);
      req_hdr = 3'h4;
      chk({got.bypass, got.l2_fwd, got.l2_lrn, got.vlan_mask}, {3'h7, 11'h7FF});
      // Events so far: port denies, ingress filter, tree discard, both learn denies
      bus(1'b0, OFS_STICKY, 32'h0);
      chk(rq, 32'h0000007B);
      bus(1'b1, OFS_STICKY, 32'h7F);
      bus(1'b0, OFS_STICKY, 32'h0);
      chk(rq, 32'h0);
      $display("test private vlan done");
      tally_and_finish();
   end
endmodule

// ===== verif/vstil_stage_model.sv
`timescale 1ns/1ps
module vstil_stage_model
   import vstil_pkg::*;
(
   input  wire logic       REF_CLK,
   input  wire logic       RESET_N,
   input  wire vstil_res_s LKP_RES,
   output vstil_res_s      last_res,
   output int              res_count
);
   // Forwarding stage keeps the newest result; the count shows no pulse was lost
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         last_res  <= '0;
         res_count <= 0;
      end else if (LKP_RES.valid === 1'b1) begin
         last_res  <= LKP_RES;
         res_count <= res_count + 1;
      end
   end
endmodule
